// ---- verilog/wake_tx_regs.sv ----
// wake pattern 3 registers and transmit control register with its control logic
`timescale 1ns/10ps
// Operation
// RULE_01: wake CRC-32 over mask-selected frame bytes
// RULE_02: expected CRC held as low/high halves
// RULE_03: first mask word bit n selects byte n+1
// RULE_04: later mask words select bytes 17 to 64
// RULE_05: ICMP checksum only for unfragmented frames
// RULE_06: TCP checksum insert when bit set
// RULE_07: IP header checksum insert when bit set
// RULE_08: flush clears queue, resets frame pointer
// RULE_09: host clears run enable before flush
// RULE_10: full duplex flow control sends PAUSE
// RULE_11: half duplex flow control uses back-pressure
// RULE_12: flow control off means none applied
// RULE_13: pad frames shorter than 64 bytes
// RULE_14: host sets CRC append with padding
// RULE_15: append 32-bit CRC when bit set
// RULE_16: run enable starts the transmit module
// RULE_17: stop only after current frame completes
// RULE_18: wake words 16-bit read-write, reset zero
// RULE_19: reserved bits and offsets read zero
module wake_tx_regs
   import wake_tx_regs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic [1:0] regByteEn,
   input wire logic [15:0] regWrData,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   // received frame stream
   input wire logic rxFrameStart,
   input wire logic rxByteValid,
   input wire logic [7:0] rxByte,
   input wire logic rxFrameEnd,
   output logic wakeMatch,
   // transmit engine status
   input wire logic txFrameActive,
   input wire logic txFrameDone,
   input wire logic txFrameFragmented,
   input wire logic [10:0] txFrameLen,
   input wire logic fullDuplex,
   input wire logic rxBufAboveThreshold,
   // transmit engine controls
   output logic txStartAllowed,
   output logic txRunning,
   output logic txQueueClear,
   output logic [5:0] txFramePtr,
   output logic icmpChecksumGen,
   output logic tcpChecksumGen,
   output logic ipChecksumGen,
   output logic padRequest,
   output logic fcsAppend,
   output logic pauseFrameReq,
   output logic backPressure
);
   logic rstMeta_q;
   logic rstSync_q;
   logic [15:0] crcLow_q;
   logic [15:0] crcHigh_q;
   logic [15:0] mask0_q;
   logic [15:0] mask1_q;
   logic [15:0] mask2_q;
   logic [15:0] mask3_q;
   logic [15:0] txCtrl_q;
   logic [15:0] rdData_d;
   logic [15:0] rdData_q;
   logic [5:0] framePtr_q;
   logic pause_q;
   logic backPress_q;
   logic aboveSeen_q;
   tx_state_t txState_q;
   tx_state_t txState_d;
   wake_pattern_if wp ();

   function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [15:0] wr,
                                              input logic [1:0] be, input logic [15:0] keep);
      logic [15:0] r;
      r = old;
      if (be[0])
      begin
         r[7:0] = wr[7:0];
      end
      if (be[1])
      begin
         r[15:8] = wr[15:8];
      end
      return r & keep;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:1] == ofs[7:1];
   endfunction

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // wake pattern 3 words
   always_ff @(posedge core_clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         crcLow_q <= WAKE3_WORD_RESET; // see RULE_18
         crcHigh_q <= WAKE3_WORD_RESET;
         mask0_q <= WAKE3_WORD_RESET;
         mask1_q <= WAKE3_WORD_RESET;
         mask2_q <= WAKE3_WORD_RESET;
         mask3_q <= WAKE3_WORD_RESET;
      end
      else if (regWrEn)
      begin
         if (hit(regAddr, WAKE3_CRC_LOW_OFS))
         begin
            crcLow_q <= mergeBytes(crcLow_q, regWrData, regByteEn, 16'hffff); // see RULE_02
         end
         if (hit(regAddr, WAKE3_CRC_HIGH_OFS))
         begin
            crcHigh_q <= mergeBytes(crcHigh_q, regWrData, regByteEn, 16'hffff); // see RULE_02
         end
         if (hit(regAddr, WAKE3_MASK_1_16_OFS))
         begin
            mask0_q <= mergeBytes(mask0_q, regWrData, regByteEn, 16'hffff); // see RULE_18
         end
         if (hit(regAddr, WAKE3_MASK_17_32_OFS))
         begin
            mask1_q <= mergeBytes(mask1_q, regWrData, regByteEn, 16'hffff);
         end
         if (hit(regAddr, WAKE3_MASK_33_48_OFS))
         begin
            mask2_q <= mergeBytes(mask2_q, regWrData, regByteEn, 16'hffff);
         end
         if (hit(regAddr, WAKE3_MASK_49_64_OFS))
         begin
            mask3_q <= mergeBytes(mask3_q, regWrData, regByteEn, 16'hffff);
         end
      end
   end

   // transmit control, reserved bits held at zero
   always_ff @(posedge core_clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         txCtrl_q <= TX_CONTROL_RESET;
      end
      else if (regWrEn && hit(regAddr, TX_CONTROL_OFS))
      begin
         txCtrl_q <= mergeBytes(txCtrl_q, regWrData, regByteEn, TX_CONTROL_WR_MASK); // see RULE_19
      end
   end

   // read mux, unmapped offsets read zero
   always_comb
   begin
      rdData_d = 16'h0000; // see RULE_19
      if (hit(regAddr, WAKE3_CRC_LOW_OFS))
      begin
         rdData_d = crcLow_q;
      end
      else if (hit(regAddr, WAKE3_CRC_HIGH_OFS))
      begin
         rdData_d = crcHigh_q;
      end
      else if (hit(regAddr, WAKE3_MASK_1_16_OFS))
      begin
         rdData_d = mask0_q;
      end
      else if (hit(regAddr, WAKE3_MASK_17_32_OFS))
      begin
         rdData_d = mask1_q;
      end
      else if (hit(regAddr, WAKE3_MASK_33_48_OFS))
      begin
         rdData_d = mask2_q;
      end
      else if (hit(regAddr, WAKE3_MASK_49_64_OFS))
      begin
         rdData_d = mask3_q;
      end
      else if (hit(regAddr, TX_CONTROL_OFS))
      begin
         rdData_d = txCtrl_q;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         rdData_q <= 16'h0000;
      end
      else if (regRdEn)
      begin
         rdData_q <= rdData_d;
      end
   end

   assign regRdData = rdData_q;

   // transmit process state
   always_comb
   begin
      txState_d = txState_q;
      case (txState_q)
         TX_STOPPED:
         begin
            if (txCtrl_q[TXC_RUN_BIT])
            begin
               txState_d = TX_RUNNING; // see RULE_16
            end
         end
         TX_RUNNING:
         begin
            if (!txCtrl_q[TXC_RUN_BIT])
            begin
               txState_d = (txFrameActive && !txFrameDone) ? TX_DRAINING : TX_STOPPED; // see RULE_17
            end
         end
         TX_DRAINING:
         begin
            if (txFrameDone || !txFrameActive)
            begin
               txState_d = TX_STOPPED; // see RULE_17
            end
         end
         default:
         begin
            txState_d = TX_STOPPED;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         txState_q <= TX_STOPPED;
      end
      else
      begin
         txState_q <= txState_d;
      end
   end

   assign txStartAllowed = txState_q == TX_RUNNING;
   assign txRunning = txState_q != TX_STOPPED;

   // frame pointer, held at start while flushing
   always_ff @(posedge core_clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         framePtr_q <= 6'h00;
      end
      else if (txCtrl_q[TXC_FLUSH_BIT])
      begin
         framePtr_q <= 6'h00; // see RULE_08
      end
      else if (txFrameDone)
      begin
         framePtr_q <= framePtr_q + 6'h01;
      end
   end

   assign txFramePtr = framePtr_q;
   assign txQueueClear = txCtrl_q[TXC_FLUSH_BIT]; // see RULE_08 see RULE_09

   // frame content options
   assign icmpChecksumGen = txCtrl_q[TXC_ICMP_CSUM_BIT] && !txFrameFragmented; // see RULE_05
   assign tcpChecksumGen = txCtrl_q[TXC_TCP_CSUM_BIT]; // see RULE_06
   assign ipChecksumGen = txCtrl_q[TXC_IP_CSUM_BIT]; // see RULE_07
   assign padRequest = txCtrl_q[TXC_PAD_BIT] && (txFrameLen < MIN_FRAME_BYTES); // see RULE_13
   assign fcsAppend = txCtrl_q[TXC_FCS_BIT]; // see RULE_15

   // flow control: pause pulse on threshold crossing, or back-pressure level
   always_ff @(posedge core_clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         aboveSeen_q <= 1'b0;
         pause_q <= 1'b0;
         backPress_q <= 1'b0;
      end
      else
      begin
         aboveSeen_q <= rxBufAboveThreshold;
         pause_q <= txCtrl_q[TXC_FLOW_CTRL_BIT] && fullDuplex &&
                    rxBufAboveThreshold && !aboveSeen_q; // see RULE_10 see RULE_12
         backPress_q <= txCtrl_q[TXC_FLOW_CTRL_BIT] && !fullDuplex &&
                        rxBufAboveThreshold; // see RULE_11 see RULE_12
      end
   end

   assign pauseFrameReq = pause_q;
   assign backPressure = backPress_q;

   // wake pattern matcher
   assign wp.crcExpect = {crcHigh_q, crcLow_q}; // see RULE_02
   assign wp.byteMask = {mask3_q, mask2_q, mask1_q, mask0_q}; // see RULE_03 see RULE_04
   assign wakeMatch = wp.wakeMatch;

   wake_pattern_match matcher
   (
      .core_clk(core_clk),
      .rstSync_b(rstSync_q),
      .rxFrameStart(rxFrameStart),
      .rxByteValid(rxByteValid),
      .rxByte(rxByte),
      .rxFrameEnd(rxFrameEnd),
      .wp(wp.match)
   );

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstSync_q);

   a_run_start: assert property ((txState_q == TX_STOPPED && txCtrl_q[TXC_RUN_BIT]) |=> txRunning) // see RULE_16
      else $error("transmit did not start on run enable");
   a_stop_drain: assert property ((txState_q == TX_DRAINING && txFrameActive && !txFrameDone) |=> txRunning) // see RULE_17
      else $error("stopped before current frame ended");
   a_flush_ptr: assert property (txCtrl_q[TXC_FLUSH_BIT] |=> framePtr_q == 6'h00) // see RULE_08
      else $error("frame pointer not reset by flush");
   a_pause_full: assert property ((txCtrl_q[TXC_FLOW_CTRL_BIT] && fullDuplex && $rose(rxBufAboveThreshold)) |-> ##1 pauseFrameReq) // see RULE_10
      else $error("no pause frame at threshold");
   a_backpress_half: assert property ((txCtrl_q[TXC_FLOW_CTRL_BIT] && !fullDuplex && rxBufAboveThreshold) |=> backPressure && !pauseFrameReq) // see RULE_11
      else $error("no back-pressure in half duplex");
   a_flow_off: assert property (!txCtrl_q[TXC_FLOW_CTRL_BIT] |=> !backPressure && !pauseFrameReq) // see RULE_12
      else $error("flow control applied while disabled");
   a_icmp_frag: assert property (txFrameFragmented |-> !icmpChecksumGen) // see RULE_05
      else $error("icmp checksum on fragmented frame");
   a_pad_short: assert property (padRequest |-> txFrameLen < MIN_FRAME_BYTES && txCtrl_q[TXC_PAD_BIT]) // see RULE_13
      else $error("padding requested for full-size frame");
   a_ctrl_reserved: assert property ((regRdEn && hit(regAddr, TX_CONTROL_OFS)) |=> regRdData[15:9] == 7'h00 && !regRdData[7]) // see RULE_19
      else $error("reserved control bits read nonzero");
   a_crc_write: assert property ((regWrEn && hit(regAddr, WAKE3_CRC_HIGH_OFS) && regByteEn == 2'b11) |=> wp.crcExpect[31:16] == $past(regWrData)) // see RULE_02
      else $error("upper crc half not written");
endmodule

// ---- verilog/wake_tx_regs_pkg.sv ----
// constants for the wake pattern 3 and transmit control register slice
package wake_tx_regs_pkg;
   // register byte offsets
   localparam logic [7:0] WAKE3_CRC_LOW_OFS = 8'h60;
   localparam logic [7:0] WAKE3_CRC_HIGH_OFS = 8'h62;
   localparam logic [7:0] WAKE3_MASK_1_16_OFS = 8'h64;
   localparam logic [7:0] WAKE3_MASK_17_32_OFS = 8'h66;
   localparam logic [7:0] WAKE3_MASK_33_48_OFS = 8'h68;
   localparam logic [7:0] WAKE3_MASK_49_64_OFS = 8'h6a;
   localparam logic [7:0] TX_CONTROL_OFS = 8'h70;
   // reset values
   localparam logic [15:0] WAKE3_WORD_RESET = 16'h0000;
   localparam logic [15:0] TX_CONTROL_RESET = 16'h0000;
   // transmit control fields
   localparam int TXC_ICMP_CSUM_BIT = 8;
   localparam int TXC_TCP_CSUM_BIT = 6;
   localparam int TXC_IP_CSUM_BIT = 5;
   localparam int TXC_FLUSH_BIT = 4;
   localparam int TXC_FLOW_CTRL_BIT = 3;
   localparam int TXC_PAD_BIT = 2;
   localparam int TXC_FCS_BIT = 1;
   localparam int TXC_RUN_BIT = 0;
   localparam logic [15:0] TX_CONTROL_WR_MASK = 16'h017f;
   // frame figures
   localparam logic [10:0] MIN_FRAME_BYTES = 11'h040;
   localparam logic [6:0] WAKE_MASK_BYTES = 7'h40;
   localparam logic [31:0] CRC32_POLY_REFL = 32'hedb88320;
   localparam logic [31:0] CRC32_INIT = 32'hffffffff;
   // transmit process states
   typedef enum logic [1:0]
   {
      TX_STOPPED = 2'b00,
      TX_RUNNING = 2'b01,
      TX_DRAINING = 2'b10
   } tx_state_t;
endpackage

// ---- verilog/wake_pattern_if.sv ----
// carrier between the register slice and the wake pattern matcher
`timescale 1ns/10ps
interface wake_pattern_if;
   logic [31:0] crcExpect;
   logic [63:0] byteMask;
   logic wakeMatch;
   modport cfg
   (
      output crcExpect,
      output byteMask,
      input wakeMatch
   );
   modport match
   (
      input crcExpect,
      input byteMask,
      output wakeMatch
   );
endinterface

// ---- verilog/wake_pattern_match.sv ----
// masked crc-32 match of received frames against wake pattern 3
`timescale 1ns/10ps
module wake_pattern_match
   import wake_tx_regs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstSync_b,
   // received byte stream
   input wire logic rxFrameStart,
   input wire logic rxByteValid,
   input wire logic [7:0] rxByte,
   input wire logic rxFrameEnd,
   // configuration and result
   wake_pattern_if.match wp
);
   logic [31:0] crc_q;
   logic [6:0] byteIdx_q;
   logic matchPulse_q;
   logic byteSel;

   function automatic logic [31:0] crc32Byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ CRC32_POLY_REFL) : (r >> 1);
      end
      return r;
   endfunction

   // only the first 64 bytes can be selected
   assign byteSel = (byteIdx_q < WAKE_MASK_BYTES) && wp.byteMask[byteIdx_q[5:0]]; // see RULE_03 see RULE_04

   always_ff @(posedge core_clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         byteIdx_q <= 7'h00;
      end
      else if (rxFrameStart)
      begin
         byteIdx_q <= 7'h00;
      end
      else if (rxByteValid && byteIdx_q < WAKE_MASK_BYTES)
      begin
         byteIdx_q <= byteIdx_q + 7'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         crc_q <= CRC32_INIT;
      end
      else if (rxFrameStart)
      begin
         crc_q <= CRC32_INIT;
      end
      else if (rxByteValid && byteSel)
      begin
         crc_q <= crc32Byte(crc_q, rxByte); // see RULE_01
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         matchPulse_q <= 1'b0;
      end
      else
      begin
         matchPulse_q <= rxFrameEnd && (~crc_q == wp.crcExpect); // see RULE_01
      end
   end

   assign wp.wakeMatch = matchPulse_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstSync_b);

   a_mask_skip: assert property ((rxByteValid && !byteSel && !rxFrameStart) |=> $stable(crc_q)) // see RULE_03
      else $error("unselected byte changed the crc");
   a_crc_restart: assert property (rxFrameStart |=> crc_q == CRC32_INIT) // see RULE_01
      else $error("crc not restarted at frame start");
   a_match_cause: assert property (wp.wakeMatch |-> $past(rxFrameEnd)) // see RULE_01
      else $error("wake match without frame end");
endmodule

// ---- bench/host_model.sv ----
// host side model that drives the register port of the slice
`timescale 1ns/10ps
module host_model
   import wake_tx_regs_pkg::*;
(
   // clock
   input wire logic core_clk,
   // register port
   output logic [7:0] regAddr,
   output logic regWrEn,
   output logic [1:0] regByteEn,
   output logic [15:0] regWrData,
   output logic regRdEn,
   input wire logic [15:0] regRdData
);
   logic [15:0] ctrlShadow;
   initial
   begin
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regByteEn = 2'b00;
      regWrData = 16'h0000;
      regRdEn = 1'b0;
      ctrlShadow = 16'h0000;
   end
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
   begin
      @(negedge core_clk);
      regAddr = a;
      regByteEn = be;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      // released lines do not keep the old value
      regAddr = ~a;
      regWrData = ~d;
      regByteEn = ~be;
   end
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
   begin
      @(negedge core_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge core_clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdData;
   end
   endtask
   task automatic setCtrl(input logic [15:0] v);
      logic [15:0] w;
   begin
      w = v;
      if (w[TXC_PAD_BIT]) w[TXC_FCS_BIT] = 1'b1;
      if (w[TXC_FLUSH_BIT])
      begin
         w[TXC_RUN_BIT] = 1'b0;
         if (ctrlShadow[TXC_RUN_BIT]) wr(TX_CONTROL_OFS, 2'b11, ctrlShadow & 16'hfffe);
      end
      wr(TX_CONTROL_OFS, 2'b11, w);
      ctrlShadow = w;
   end
   endtask
endmodule

// ---- bench/test_wake_tx_regs.sv ----
// self-checking bench for the wake pattern 3 and transmit control slice
`timescale 1ns/10ps
module test_wake_tx_regs
   import wake_tx_regs_pkg::*;
;
   logic core_clk, rst_b, regWrEn, regRdEn, rxFrameStart, rxByteValid, rxFrameEnd, wakeMatch;
   logic [7:0] regAddr, rxByte;
   logic [1:0] regByteEn, be;
   logic [15:0] regWrData, regRdData, rd, ce;
   logic txFrameActive, txFrameDone, txFrameFragmented, fullDuplex, rxBufAboveThreshold;
   logic [10:0] txFrameLen;
   logic txStartAllowed, txRunning, txQueueClear, icmpChecksumGen, tcpChecksumGen;
   logic ipChecksumGen, padRequest, fcsAppend, pauseFrameReq, backPressure, hit;
   logic [5:0] txFramePtr;
   logic [63:0] mask;
   logic [31:0] crc;
   logic [7:0] frame[$];
   logic [15:0] regM[9];
   logic [7:0] ofs[9] = '{8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6e, 8'h5e};
   int error_cnt, total_checks, ptrM, k, n;

   host_model u_host_model (.core_clk, .regAddr, .regWrEn, .regByteEn, .regWrData, .regRdEn,
      .regRdData);
   wake_tx_regs u_wake_tx_regs (.core_clk, .rst_b, .regAddr, .regWrEn, .regByteEn, .regWrData,
      .regRdEn, .regRdData, .rxFrameStart, .rxByteValid, .rxByte, .rxFrameEnd, .wakeMatch,
      .txFrameActive, .txFrameDone, .txFrameFragmented, .txFrameLen, .fullDuplex,
      .rxBufAboveThreshold, .txStartAllowed, .txRunning, .txQueueClear, .txFramePtr,
      .icmpChecksumGen, .tcpChecksumGen, .ipChecksumGen, .padRequest, .fcsAppend,
      .pauseFrameReq, .backPressure);

   always #5 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
   begin
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task automatic close_out;
   begin
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   // value the host really leaves in the control word
   function automatic logic [15:0] fixCtrl(input logic [15:0] v);
   begin
      if (v[2]) v[1] = 1'b1;
      if (v[4]) v[0] = 1'b0;
      return v & TX_CONTROL_WR_MASK;
   end
   endfunction
   // reflected crc-32 over the masked first 64 bytes
   function automatic logic [31:0] crcOf(input logic [7:0] f[$], input logic [63:0] m);
      logic [31:0] c;
   begin
      c = 32'hffffffff;
      for (int i = 0; i < 64 && i < f.size(); i++)
         if (m[i])
         begin
            c = c ^ {24'h0, f[i]};
            for (int b = 0; b < 8; b++)
               c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
         end
      return ~c;
   end
   endfunction
   task automatic sendFrame;
   begin
      @(negedge core_clk);
      rxFrameStart = 1'b1;
      @(negedge core_clk);
      rxFrameStart = 1'b0;
      foreach (frame[i])
      begin
         rxByteValid = 1'b1;
         rxByte = frame[i];
         @(negedge core_clk);
      end
      rxByteValid = 1'b0;
      rxByte = ~rxByte;
      rxFrameEnd = 1'b1;
      hit = 1'b0;
      repeat (3)
      begin
         @(negedge core_clk);
         rxFrameEnd = 1'b0;
         hit = hit | wakeMatch;
      end
   end
   endtask
   task automatic pulseDone;
   begin
      @(negedge core_clk);
      txFrameDone = 1'b1;
      @(negedge core_clk);
      txFrameDone = 1'b0;
      txFrameActive = 1'b0;
      ptrM = ptrM + 1;
   end
   endtask

   initial
   begin
      #(20000 * 10);
      error_cnt++;
      close_out();
   end

   initial
   begin
      {core_clk, rst_b, rxFrameStart, rxByteValid, rxFrameEnd, rxByte} = '0;
      {txFrameActive, txFrameDone, txFrameFragmented, fullDuplex, rxBufAboveThreshold} = '0;
      txFrameLen = 11'h000;
      error_cnt = 0;
      total_checks = 0;
      ptrM = 0;
      void'($urandom(32'h94a0));
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst_b = 1'b1;
      repeat (3) @(posedge core_clk);
      // reset values, then random byte-lane writes including unmapped words
      for (k = 0; k < 9; k++)
      begin
         regM[k] = 16'h0000;
         u_host_model.rd(ofs[k], rd);
         chk("reset word", rd, 0);
      end
      u_host_model.rd(TX_CONTROL_OFS, rd);
      chk("reset control", rd, 0);
      for (n = 0; n < 24; n++)
      begin
         k = $urandom_range(8);
         be = 2'($urandom);
         ce = 16'($urandom);
         u_host_model.wr(ofs[k], be, ce);
         if (k < 6 && be[0]) regM[k][7:0] = ce[7:0];
         if (k < 6 && be[1]) regM[k][15:8] = ce[15:8];
      end
      for (k = 0; k < 9; k++)
      begin
         u_host_model.rd(ofs[k], rd);
         chk("word", rd, regM[k]);
      end
      // control fields against frame status
      for (n = 0; n < 10; n++)
      begin
         rd = 16'($urandom);
         ce = fixCtrl(rd);
         u_host_model.setCtrl(rd);
         u_host_model.rd(TX_CONTROL_OFS, rd);
         chk("control", rd, ce);
         for (k = 0; k < 4; k++)
         begin
            txFrameFragmented = k[0];
            txFrameLen = k[1] ? 11'(64 + $urandom_range(n)) : 11'(63 - $urandom_range(n));
            @(negedge core_clk);
            chk("icmp", icmpChecksumGen, ce[8] & !k[0]);
            chk("pad", padRequest, ce[2] & !k[1]);
         end
         chk("tcp", tcpChecksumGen, ce[6]);
         chk("ip", ipChecksumGen, ce[5]);
         chk("fcs", fcsAppend, ce[1]);
         chk("clear", txQueueClear, ce[4]);
      end
      // run, then stop held off by a frame in flight
      u_host_model.setCtrl(16'h0001);
      repeat (2) @(negedge core_clk);
      chk("start", txStartAllowed, 1);
      chk("running", txRunning, 1);
      txFrameActive = 1'b1;
      u_host_model.setCtrl(16'h0000);
      repeat (5) @(negedge core_clk);
      chk("draining", txRunning, 1);
      chk("no start", txStartAllowed, 0);
      ptrM = 0;
      u_host_model.setCtrl(16'h0010);
      u_host_model.setCtrl(16'h0000);
      pulseDone();
      repeat (2) @(negedge core_clk);
      chk("stopped", txRunning, 0);
      // pointer advance, flush with run cleared first, then flush released
      pulseDone();
      pulseDone();
      @(negedge core_clk);
      chk("pointer", txFramePtr, ptrM);
      u_host_model.setCtrl(16'h0011);
      pulseDone();
      chk("flush clear", txQueueClear, 1);
      chk("flush pointer", txFramePtr, 0);
      chk("flush run", txStartAllowed, 0);
      u_host_model.setCtrl(16'h0000);
      ptrM = 0;
      pulseDone();
      @(negedge core_clk);
      chk("after flush", txFramePtr, ptrM);
      // flow control in both duplex modes, on and off
      for (k = 0; k < 4; k++)
      begin
         u_host_model.setCtrl(k[1] ? 16'h0008 : 16'h0000);
         fullDuplex = k[0];
         repeat (2) @(negedge core_clk);
         rxBufAboveThreshold = 1'b1;
         n = 0;
         repeat (4)
         begin
            @(negedge core_clk);
            n = n + (pauseFrameReq === 1'b1);
         end
         chk("pause", n, k == 3);
         chk("backpressure", backPressure, k == 2);
         rxBufAboveThreshold = 1'b0;
         repeat (2) @(negedge core_clk);
         chk("backpressure off", backPressure, 0);
      end
      // wake pattern with end bytes masked in and one byte masked out
      mask = ({$urandom, $urandom} & ~64'h20) | 64'h8000000000000001;
      repeat (70) frame.push_back(8'($urandom));
      crc = crcOf(frame, mask);
      u_host_model.wr(WAKE3_CRC_LOW_OFS, 2'b11, crc[15:0]);
      u_host_model.wr(WAKE3_CRC_HIGH_OFS, 2'b11, crc[31:16]);
      for (k = 0; k < 4; k++)
         u_host_model.wr(ofs[k + 2], 2'b11, mask[k * 16 +: 16]);
      sendFrame();
      chk("wake", hit, 1);
      for (k = 0; k < 5; k++)
      begin
         n = (k == 0) ? 0 : (k == 1) ? 63 : (k == 2) ? 5 : (k == 3) ? 66 : 16;
         frame[n] = ~frame[n];
         sendFrame();
         chk("wake edit", hit, crcOf(frame, mask) == crc);
         frame[n] = ~frame[n];
      end
      close_out();
   end
endmodule
